/* File: hw/lpmc_pkg.sv */
// package: constants, register map and types of the low-power mode controller
package lpmc_pkg;

    // ----------------------------------------------------------------
    // bus and field widths
    // ----------------------------------------------------------------
    localparam int DW = 8;
    localparam int AW = 8;
    localparam int NEVT = 2;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_PWR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_REG_CTRL = 8'h01;
    localparam logic [AW-1:0] ADDR_ANA_EN = 8'h02;
    localparam logic [AW-1:0] ADDR_CLK_SEL = 8'h03;
    localparam logic [AW-1:0] ADDR_PM_VAL = 8'h04;
    localparam logic [AW-1:0] ADDR_PM_MASK = 8'h05;
    localparam logic [AW-1:0] ADDR_PM_CTRL = 8'h06;
    localparam logic [AW-1:0] ADDR_INT_STAT = 8'h07;
    localparam logic [AW-1:0] ADDR_INT_CLR = 8'h08;
    localparam logic [AW-1:0] ADDR_INT_EN = 8'h09;
    localparam logic [AW-1:0] ADDR_MODE = 8'h0A;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int REG_SDSEL_BIT = 0;
    localparam int CLK_ALT_BIT = 0;
    localparam int PM_WAKE_BIT = 0;
    localparam int EVT_PM_BIT = 0;
    localparam int EVT_WAKE_BIT = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DW-1:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_HOLD_NS = 1000;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCW = 8;
    localparam logic [RCW-1:0] RESET_LAST = RCW'(RESET_HOLD_CYC - 1);

    // ----------------------------------------------------------------
    // modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LPMC_RESET,
        LPMC_NORMAL,
        LPMC_IDLE,
        LPMC_STOP,
        LPMC_SHUTDOWN
    } lpmc_state_t;

endpackage : lpmc_pkg

/* File: hw/lpmc_port_match.sv */
// port-change detector: flags a new mismatch between masked pins and match value
`timescale 1ns/1ns
`default_nettype none
module lpmc_port_match
    import lpmc_pkg::*;
#(
    parameter int PW = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clear,
    input wire logic [PW-1:0] pins,
    input wire logic [PW-1:0] match_val,
    input wire logic [PW-1:0] match_mask,
    output logic evt
);

    // ----------------------------------------------------------------
    // mismatch edge
    // ----------------------------------------------------------------
    logic diff_r;
    logic diff_nxt;
    logic evt_r;
    logic evt_nxt;

    always_comb begin
        diff_nxt = |((pins ^ match_val) & match_mask);
        evt_nxt = diff_nxt & ~diff_r & ~clear;
        if (clear) begin
            diff_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            diff_r <= 1'b0;
            evt_r <= 1'b0;
        end else begin
            diff_r <= diff_nxt;
            evt_r <= evt_nxt;
        end
    end

    assign evt = evt_r;

endmodule : lpmc_port_match
`default_nettype wire

/* File: hw/lpmc_top.sv */
// low-power mode controller: idle, stop, shutdown, reset hold and port-change wake
//
// Overview of operation
// - Setting the idle request halts the core once the setting instruction completes, state kept.
// - In idle an enabled interrupt clears the idle request and resumes the core to service it.
// - Idle exit by interrupt does not reset the core, so it continues after the setting instruction.
// - A reset ending idle runs the normal reset sequence and restarts fetch at address 0x0000.
// - Stop request with shutdown select clear enters stop: oscillator, core, peripherals halted, regulator on.
// - Stop is left only by an internal or external reset, never by an interrupt.
// - Stop request with shutdown select set enters stop first, then powers the core regulator down.
// - In shutdown the regulator and analog are off, clocks stopped, and output pins hold their state.
// - Only the external pin reset or power-on reset brings the device out of shutdown.
// - Each analog peripheral has its own enable, and enabled ones keep running in stop.
// - Outside shutdown, the device stays in reset while the supply monitor reports the supply below threshold.
// - The port-change detector sees a pin change, always sets its interrupt flag, and also wakes from idle when its wake bit is set.
// - Leaving any reset clears the program counter and selects the low-power oscillator.
`timescale 1ns/1ns
`default_nettype none
module lpmc_top
    import lpmc_pkg::*;
#(
    parameter int PW = 8,
    parameter int NA = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DW-1:0] rdata,
    input wire logic instr_done,
    input wire logic irq_req,
    input wire logic ext_reset,
    input wire logic por_reset,
    input wire logic int_reset,
    input wire logic supply_low,
    input wire logic [PW-1:0] port_pins,
    output logic core_halt,
    output logic osc_en,
    output logic periph_clk_en,
    output logic regulator_en,
    output logic [NA-1:0] analog_en,
    output logic pin_hold,
    output logic sys_reset,
    output logic pc_clear,
    output logic [15:0] boot_addr,
    output logic clk_sel_lpo,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    lpmc_state_t state_r, state_nxt;
    logic [RCW-1:0] rcnt_r, rcnt_nxt;
    logic [NA-1:0] anaen_r, anaen_nxt, ana_out_r, ana_out_nxt;
    logic [PW-1:0] pm_val_r, pm_val_nxt, pm_mask_r, pm_mask_nxt;
    logic [NEVT-1:0] stat_r, stat_nxt, inten_r, inten_nxt;
    logic [DW-1:0] rdata_r, rdata_nxt;
    logic [15:0] boot_addr_r, boot_addr_nxt;
    logic idle_req_r, idle_req_nxt, stop_req_r, stop_req_nxt, sdsel_r, sdsel_nxt;
    logic clk_alt_r, clk_alt_nxt, pm_wake_r, pm_wake_nxt, core_halt_r, core_halt_nxt;
    logic osc_en_r, osc_en_nxt, pclk_r, pclk_nxt, reg_en_r, reg_en_nxt;
    logic pin_hold_r, pin_hold_nxt, sys_reset_r, sys_reset_nxt, pc_clear_r, pc_clear_nxt;
    logic lpo_r, lpo_nxt, irq_r, irq_nxt, pm_evt, any_reset, hard_reset, wake;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [DW-1:0] widen(input logic [PW-1:0] v);
        widen = DW'(v);
    endfunction : widen

    // ----------------------------------------------------------------
    // port-change detector
    // ----------------------------------------------------------------
    lpmc_port_match #(
        .PW(PW)
    ) u_pm (
        .clock(clock),
        .resetn(resetn),
        .clear(sys_reset_r),
        .pins(port_pins),
        .match_val(pm_val_r),
        .match_mask(pm_mask_r),
        .evt(pm_evt)
    );

    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    always_comb begin
        hard_reset = ext_reset | por_reset;
        any_reset = hard_reset | int_reset | supply_low;
        wake = irq_req | (pm_evt & pm_wake_r);
        state_nxt = state_r;
        rcnt_nxt = rcnt_r;
        case (state_r)
            LPMC_RESET: begin
                if (any_reset) begin
                    rcnt_nxt = '0;
                end else if (rcnt_r == RESET_LAST) begin
                    state_nxt = LPMC_NORMAL;
                end else begin
                    rcnt_nxt = rcnt_r + RCW'(1);
                end
            end
            LPMC_NORMAL: begin
                if (any_reset) begin
                    state_nxt = LPMC_RESET;
                end else if (instr_done && stop_req_r) begin
                    state_nxt = LPMC_STOP;
                end else if (instr_done && idle_req_r) begin
                    state_nxt = LPMC_IDLE;
                end
            end
            LPMC_IDLE: begin
                if (any_reset) begin
                    state_nxt = LPMC_RESET;
                end else if (wake) begin
                    state_nxt = LPMC_NORMAL;
                end
            end
            LPMC_STOP: begin
                if (any_reset) begin
                    state_nxt = LPMC_RESET;
                end else if (sdsel_r) begin
                    state_nxt = LPMC_SHUTDOWN;
                end
            end
            LPMC_SHUTDOWN: begin
                if (hard_reset) begin
                    state_nxt = LPMC_RESET;
                end
            end
            default: state_nxt = LPMC_RESET;
        endcase
        if (state_nxt == LPMC_RESET && state_r != LPMC_RESET) begin
            rcnt_nxt = '0;
        end
    end

    // ----------------------------------------------------------------
    // outputs from the next mode
    // ----------------------------------------------------------------
    always_comb begin
        core_halt_nxt = 1'b1;
        osc_en_nxt = 1'b1;
        pclk_nxt = 1'b1;
        reg_en_nxt = 1'b1;
        ana_out_nxt = anaen_nxt;
        pin_hold_nxt = 1'b0;
        sys_reset_nxt = 1'b0;
        pc_clear_nxt = 1'b0;
        boot_addr_nxt = boot_addr_r;
        lpo_nxt = ~clk_alt_nxt;
        case (state_nxt)
            LPMC_RESET: sys_reset_nxt = 1'b1;
            LPMC_NORMAL: begin
                core_halt_nxt = 1'b0;
                if (state_r == LPMC_RESET) begin
                    pc_clear_nxt = 1'b1;
                    boot_addr_nxt = RESET_VECTOR;
                end
            end
            LPMC_IDLE: core_halt_nxt = 1'b1;
            LPMC_STOP: begin
                osc_en_nxt = 1'b0;
                pclk_nxt = 1'b0;
                pin_hold_nxt = 1'b1;
                ana_out_nxt = anaen_r;
            end
            LPMC_SHUTDOWN: begin
                osc_en_nxt = 1'b0;
                pclk_nxt = 1'b0;
                reg_en_nxt = 1'b0;
                ana_out_nxt = '0;
                pin_hold_nxt = 1'b1;
            end
            default: sys_reset_nxt = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // registers and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        idle_req_nxt = idle_req_r;
        stop_req_nxt = stop_req_r;
        sdsel_nxt = sdsel_r;
        anaen_nxt = anaen_r;
        clk_alt_nxt = clk_alt_r;
        pm_val_nxt = pm_val_r;
        pm_mask_nxt = pm_mask_r;
        pm_wake_nxt = pm_wake_r;
        inten_nxt = inten_r;
        stat_nxt = stat_r;
        rdata_nxt = RST_BYTE;
        if (wr_stb) begin
            case (addr)
                ADDR_PWR_CTRL: begin
                    idle_req_nxt = idle_req_r | wdata[PWR_IDLE_BIT];
                    stop_req_nxt = stop_req_r | wdata[PWR_STOP_BIT];
                end
                ADDR_REG_CTRL: sdsel_nxt = wdata[REG_SDSEL_BIT];
                ADDR_ANA_EN: anaen_nxt = wdata[NA-1:0];
                ADDR_CLK_SEL: clk_alt_nxt = wdata[CLK_ALT_BIT];
                ADDR_PM_VAL: pm_val_nxt = wdata[PW-1:0];
                ADDR_PM_MASK: pm_mask_nxt = wdata[PW-1:0];
                ADDR_PM_CTRL: pm_wake_nxt = wdata[PM_WAKE_BIT];
                ADDR_INT_EN: inten_nxt = wdata[NEVT-1:0];
                ADDR_INT_CLR: stat_nxt = stat_r & ~wdata[NEVT-1:0];
                default: stat_nxt = stat_r;
            endcase
        end
        if (pm_evt) begin
            stat_nxt[EVT_PM_BIT] = 1'b1;
        end
        if (state_r == LPMC_IDLE && state_nxt == LPMC_NORMAL) begin
            idle_req_nxt = 1'b0;
            stat_nxt[EVT_WAKE_BIT] = 1'b1;
        end
        if (rd_stb) begin
            case (addr)
                ADDR_PWR_CTRL: rdata_nxt = DW'({stop_req_r, idle_req_r});
                ADDR_REG_CTRL: rdata_nxt = DW'(sdsel_r);
                ADDR_ANA_EN: rdata_nxt = DW'(anaen_r);
                ADDR_CLK_SEL: rdata_nxt = DW'(clk_alt_r);
                ADDR_PM_VAL: rdata_nxt = widen(pm_val_r);
                ADDR_PM_MASK: rdata_nxt = widen(pm_mask_r);
                ADDR_PM_CTRL: rdata_nxt = DW'(pm_wake_r);
                ADDR_INT_STAT: rdata_nxt = DW'(stat_r);
                ADDR_INT_EN: rdata_nxt = DW'(inten_r);
                ADDR_MODE: rdata_nxt = DW'(state_r);
                default: rdata_nxt = RST_BYTE;
            endcase
        end
        if (state_nxt == LPMC_RESET || state_r == LPMC_RESET) begin
            idle_req_nxt = 1'b0;
            stop_req_nxt = 1'b0;
            sdsel_nxt = 1'b0;
            anaen_nxt = '0;
            clk_alt_nxt = 1'b0;
            pm_val_nxt = '0;
            pm_mask_nxt = '0;
            pm_wake_nxt = 1'b0;
            inten_nxt = '0;
            stat_nxt = '0;
        end
        irq_nxt = |(stat_nxt & inten_nxt);
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= LPMC_RESET;
            rcnt_r <= '0;
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
            sdsel_r <= 1'b0;
            anaen_r <= '0;
            clk_alt_r <= 1'b0;
            pm_val_r <= '0;
            pm_mask_r <= '0;
            pm_wake_r <= 1'b0;
            stat_r <= '0;
            inten_r <= '0;
            rdata_r <= RST_BYTE;
            core_halt_r <= 1'b1;
            osc_en_r <= 1'b1;
            pclk_r <= 1'b1;
            reg_en_r <= 1'b1;
            ana_out_r <= '0;
            pin_hold_r <= 1'b0;
            sys_reset_r <= 1'b1;
            pc_clear_r <= 1'b0;
            boot_addr_r <= RESET_VECTOR;
            lpo_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rcnt_r <= rcnt_nxt;
            idle_req_r <= idle_req_nxt;
            stop_req_r <= stop_req_nxt;
            sdsel_r <= sdsel_nxt;
            anaen_r <= anaen_nxt;
            clk_alt_r <= clk_alt_nxt;
            pm_val_r <= pm_val_nxt;
            pm_mask_r <= pm_mask_nxt;
            pm_wake_r <= pm_wake_nxt;
            stat_r <= stat_nxt;
            inten_r <= inten_nxt;
            rdata_r <= rdata_nxt;
            core_halt_r <= core_halt_nxt;
            osc_en_r <= osc_en_nxt;
            pclk_r <= pclk_nxt;
            reg_en_r <= reg_en_nxt;
            ana_out_r <= ana_out_nxt;
            pin_hold_r <= pin_hold_nxt;
            sys_reset_r <= sys_reset_nxt;
            pc_clear_r <= pc_clear_nxt;
            boot_addr_r <= boot_addr_nxt;
            lpo_r <= lpo_nxt;
            irq_r <= irq_nxt;
        end
    end
    assign rdata = rdata_r;
    assign core_halt = core_halt_r;
    assign osc_en = osc_en_r;
    assign periph_clk_en = pclk_r;
    assign regulator_en = reg_en_r;
    assign analog_en = ana_out_r;
    assign pin_hold = pin_hold_r;
    assign sys_reset = sys_reset_r;
    assign pc_clear = pc_clear_r;
    assign boot_addr = boot_addr_r;
    assign clk_sel_lpo = lpo_r;
    assign irq = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_IDLE_ENTRY: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_NORMAL && idle_req_r && !stop_req_r && instr_done && !any_reset)
        |=> (state_r == LPMC_IDLE && core_halt_r && pclk_r && !sys_reset_r)) else $error("idle entry missed");
    AST_IDLE_WAKE: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_IDLE && irq_req && !any_reset)
        |=> (state_r == LPMC_NORMAL && !idle_req_r && !core_halt_r)) else $error("idle wake missed");
    AST_WAKE_NO_RESET: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_IDLE && wake && !any_reset) |=> (!pc_clear_r && !sys_reset_r))
        else $error("idle wake disturbed the program counter");
    AST_RESET_EXIT: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_RESET && rcnt_r == RESET_LAST && !any_reset)
        |=> (pc_clear_r && boot_addr_r == RESET_VECTOR) ##1 !pc_clear_r) else $error("reset exit sequence wrong");
    AST_STOP_ENTRY: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_NORMAL && stop_req_r && instr_done && !any_reset)
        |=> (state_r == LPMC_STOP && !osc_en_r && !pclk_r && core_halt_r && reg_en_r)) else $error("stop entry wrong");
    AST_STOP_NO_IRQ_EXIT: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_STOP && !sdsel_r && !any_reset) |=> (state_r == LPMC_STOP))
        else $error("stop left without reset");
    AST_SHUTDOWN_SEQ: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_STOP && sdsel_r && !any_reset)
        |=> (state_r == LPMC_SHUTDOWN && !reg_en_r)) else $error("shutdown did not follow stop");
    AST_SHUTDOWN_OUTS: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_SHUTDOWN) |-> (!reg_en_r && !osc_en_r && pin_hold_r && ana_out_r == '0))
        else $error("shutdown outputs wrong");
    AST_SHUTDOWN_EXIT: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_SHUTDOWN && !ext_reset && !por_reset) |=> (state_r == LPMC_SHUTDOWN))
        else $error("shutdown left by a soft reset");
    AST_ANALOG_STOP: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_STOP) |-> (ana_out_r == anaen_r)) else $error("analog enables not kept in stop");
    AST_SUPPLY_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        (supply_low && state_r != LPMC_SHUTDOWN) |=> (sys_reset_r && state_r == LPMC_RESET))
        else $error("supply low did not hold reset");
    AST_PM_WAKE: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_IDLE && pm_evt && pm_wake_r && !any_reset)
        |=> (state_r == LPMC_NORMAL && stat_r[EVT_PM_BIT])) else $error("port change did not wake");
    AST_LPO_AFTER_RESET: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_RESET && !any_reset && rcnt_r == RESET_LAST) |=> lpo_r)
        else $error("low-power oscillator not selected");
    AST_BOTH_IS_STOP: assert property (@(posedge clock) disable iff (!resetn)
        (state_r == LPMC_NORMAL && idle_req_r && stop_req_r && instr_done && !any_reset)
        |=> (state_r == LPMC_STOP)) else $error("idle won over stop");

endmodule : lpmc_top
`default_nettype wire

/* File: verification/lpmc_core_model.sv */
// core model: instruction completions and interrupt request
`timescale 1ns/1ns
`default_nettype none
module lpmc_core_model (
    input wire logic clock,
    input wire logic core_halt,
    input wire logic sys_reset,
    input wire logic slow,
    input wire logic irq_want,
    output logic instr_done,
    output logic irq_req
);
    initial begin
        instr_done = 1'b0;
        irq_req = 1'b0;
    end
    // completes an instruction each cycle, or every other one when slow
    always @(posedge clock) begin
        instr_done <= !core_halt && !sys_reset && !(slow && instr_done);
        irq_req <= irq_want;
    end
endmodule : lpmc_core_model
`default_nettype wire

/* File: verification/tb_lpmc_top.sv */
// testbench: low-power mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_lpmc_top;
    import lpmc_pkg::*;
    logic clock = 0, resetn = 0, wr_stb = 0, rd_stb = 0, supply_low = 0, slow = 0, irq_want = 0, rd_seen = 0;
    logic [2:0] rs = 3'h0;
    logic [AW-1:0] addr = 8'h00;
    logic [DW-1:0] wdata = 8'h00, rdata, r;
    logic [7:0] port_pins = 8'h00;
    logic instr_done, irq_req, core_halt, osc_en, periph_clk_en, regulator_en, pin_hold, sys_reset, pc_clear;
    logic clk_sel_lpo, irq;
    logic [3:0] analog_en, a;
    logic [15:0] boot_addr;
    logic [DW-1:0] expq[$];
    int fail_count = 0, samples_checked = 0, cyc = 0, pc_pulses = 0;

    always #50 clock = ~clock;

    lpmc_top #(.PW(8), .NA(4)) dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .instr_done(instr_done), .irq_req(irq_req),
        .ext_reset(rs[0]), .por_reset(rs[1]), .int_reset(rs[2]), .supply_low(supply_low),
        .port_pins(port_pins), .core_halt(core_halt), .osc_en(osc_en), .periph_clk_en(periph_clk_en),
        .regulator_en(regulator_en), .analog_en(analog_en), .pin_hold(pin_hold), .sys_reset(sys_reset),
        .pc_clear(pc_clear), .boot_addr(boot_addr), .clk_sel_lpo(clk_sel_lpo), .irq(irq));

    lpmc_core_model core (.clock(clock), .core_halt(core_halt), .sys_reset(sys_reset), .slow(slow),
        .irq_want(irq_want), .instr_done(instr_done), .irq_req(irq_req));

    task automatic tally_and_finish;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock);
        addr <= ad;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clock);
        addr <= ad;
        rd_stb <= 1'b1;
        expq.push_back(e);
        @(posedge clock);
        rd_stb <= 1'b0;
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : wait_n

    task automatic pulse(input logic [2:0] m);
        @(posedge clock);
        rs <= m;
        @(posedge clock);
        rs <= 3'h0;
    endtask : pulse

    task automatic boot;
        repeat (2) @(posedge clock);
        while (sys_reset !== 1'b0) @(posedge clock);
        @(negedge clock);
    endtask : boot

    // read data stands only in the cycle after the strobe
    always @(posedge clock) rd_seen <= rd_stb;
    always @(negedge clock) if (rd_seen) chk("rdata", 16'(expq.pop_front()), 16'(rdata));
    // counts the one-cycle restart pulses
    always @(negedge clock) pc_pulses += int'(pc_clear);

    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            tally_and_finish;
        end
    end

    initial begin
        r = 8'($urandom(87));
        a = 4'($urandom);
        slow <= 1'($urandom);
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        boot;
        chk("clk_sel_lpo", 16'h0001, 16'(clk_sel_lpo));
        chk("boot_addr", 16'h0000, boot_addr);
        rd(ADDR_MODE, 8'h01);
        rd(8'h20, 8'h00);
        wr(ADDR_INT_EN, 8'h03);
        wr(ADDR_PWR_CTRL, 8'h01);
        wait_n(4);
        chk("core_halt", 16'h0001, 16'(core_halt));
        chk("periph_clk_en", 16'h0001, 16'(periph_clk_en));
        rd(ADDR_MODE, 8'h02);
        irq_want <= 1'b1;
        wait_n(4);
        irq_want <= 1'b0;
        chk("core_halt", 16'h0000, 16'(core_halt));
        rd(ADDR_PWR_CTRL, 8'h00);
        rd(ADDR_INT_STAT, 8'h02);
        wait_n(1);
        chk("irq", 16'h0001, 16'(irq));
        wr(ADDR_INT_CLR, 8'h03);
        wait_n(2);
        chk("irq", 16'h0000, 16'(irq));
        port_pins <= r;
        wr(ADDR_PM_VAL, r);
        wr(ADDR_PM_MASK, 8'hFF);
        wr(ADDR_PM_CTRL, 8'h01);
        wr(ADDR_PWR_CTRL, 8'h01);
        wait_n(4);
        port_pins <= r ^ 8'h10;
        wait_n(5);
        chk("core_halt", 16'h0000, 16'(core_halt));
        chk("irq", 16'h0001, 16'(irq));
        rd(ADDR_INT_STAT, 8'h03);
        wr(ADDR_ANA_EN, 8'(a));
        wr(ADDR_PWR_CTRL, 8'h03);
        wait_n(4);
        chk("osc_en", 16'h0000, 16'(osc_en));
        chk("periph_clk_en", 16'h0000, 16'(periph_clk_en));
        chk("regulator_en", 16'h0001, 16'(regulator_en));
        chk("analog_en", 16'(a), 16'(analog_en));
        rd(ADDR_MODE, 8'h03);
        irq_want <= 1'b1;
        wait_n(5);
        irq_want <= 1'b0;
        chk("core_halt", 16'h0001, 16'(core_halt));
        pulse(3'h4);
        boot;
        chk("boot_addr", 16'h0000, boot_addr);
        rd(ADDR_ANA_EN, 8'h00);
        wr(ADDR_REG_CTRL, 8'h01);
        wr(ADDR_PWR_CTRL, 8'h02);
        wait_n(4);
        chk("regulator_en", 16'h0000, 16'(regulator_en));
        chk("pin_hold", 16'h0001, 16'(pin_hold));
        chk("analog_en", 16'h0000, 16'(analog_en));
        pulse(3'h4);
        wait_n(15);
        chk("regulator_en", 16'h0000, 16'(regulator_en));
        pulse(3'h1);
        boot;
        rd(ADDR_MODE, 8'h01);
        supply_low <= 1'b1;
        wait_n(30);
        chk("sys_reset", 16'h0001, 16'(sys_reset));
        supply_low <= 1'b0;
        boot;
        wr(ADDR_CLK_SEL, 8'h01);
        wait_n(1);
        chk("clk_sel_lpo", 16'h0000, 16'(clk_sel_lpo));
        pulse(3'h2);
        boot;
        chk("clk_sel_lpo", 16'h0001, 16'(clk_sel_lpo));
        wait_n(2);
        chk("pc_clear", 16'h0005, 16'(pc_pulses));
        tally_and_finish;
    end
endmodule : tb_lpmc_top
`default_nettype wire
